// >>> verilog/dbs_pkg.sv
`default_nettype none
package dbs_pkg;

   // ==========================================================
   // Bus geometry
   localparam int DATA_W_DEF   = 36;
   localparam int ADDR_W_DEF   = 20;
   localparam int LANE_W       = 9;
   localparam int LANES_DEF    = 4;
   localparam int BURST_LEN    = 2;

   // ==========================================================
   // Pipeline stages, counted in half clock periods after the command edge
   localparam int PIPE_DEPTH     = 8;
   localparam int WR_WORD0_STAGE = 2;
   localparam int WR_WORD1_STAGE = 3;
   localparam int RD_WORD0_STAGE = 5;
   localparam int RD_WORD1_STAGE = 6;
   localparam int VALID_FIRST    = 4;
   localparam int VALID_LAST     = 5;
   localparam int TERM_OFF_FIRST = 4;
   localparam int TERM_OFF_LAST  = 7;

   // ==========================================================
   // Timing
   localparam int REF_CLK_MHZ   = 100;
   localparam int SETUP_TIME_US = 20;
   localparam int SETUP_CYCLES  = SETUP_TIME_US * REF_CLK_MHZ;
   localparam int PLL_MIN_MHZ   = 250;
   localparam int HALF_DIV_DEF  = 2;
   localparam int SETUP_CNT_W   = 12;

   // ==========================================================
   // Controller states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_WRITE = 3'b010,
      ST_READ  = 3'b100
   } dbs_state_e;

endpackage : dbs_pkg
`default_nettype wire

// >>> verilog/dbs_bus_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dbs_bus_if #(
   parameter int DATA_W = dbs_pkg::DATA_W_DEF,
   parameter int ADDR_W = dbs_pkg::ADDR_W_DEF,
   parameter int LANES  = dbs_pkg::LANES_DEF
);
   // Clock phases, as one-cycle enables of ref_clk, and the clock level.
   logic              kRise;
   logic              kbRise;
   logic              kLevel;
   // Command and write side.
   logic              cycleLoadN;
   logic              rdWrN;
   logic [ADDR_W-1:0] addr;
   logic [LANES-1:0]  byteLaneWriteMaskN;
   logic              pllBypassN;
   logic              terminationRangeSelect;
   // Shared data pins.
   logic [DATA_W-1:0] ctlDqOut;
   logic              ctlDqOe;
   logic [DATA_W-1:0] devDqOut;
   logic              devDqOe;
   logic [DATA_W-1:0] dq;
   // Read side and status.
   logic              readValidFlag;
   logic              echoClockPair;
   logic              echoClockPairN;
   logic              dqTermEn;
   logic              maskTermEn;
   logic              clkTermEn;
   logic              termRangeHigh;

   // Wire level of the shared bus; an undriven bus reads as zero.
   assign dq = devDqOe ? devDqOut : (ctlDqOe ? ctlDqOut : '0);

   modport dev (
      input  kRise, kbRise, kLevel, cycleLoadN, rdWrN, addr, byteLaneWriteMaskN,
      input  pllBypassN, terminationRangeSelect, dq,
      output devDqOut, devDqOe, readValidFlag, echoClockPair, echoClockPairN,
      output dqTermEn, maskTermEn, clkTermEn, termRangeHigh
   );
   modport ctl (
      output kRise, kbRise, kLevel, cycleLoadN, rdWrN, addr, byteLaneWriteMaskN,
      output pllBypassN, terminationRangeSelect, ctlDqOut, ctlDqOe,
      input  dq, devDqOe, readValidFlag, echoClockPair, echoClockPairN
   );
endinterface : dbs_bus_if
`default_nettype wire

// >>> verilog/dbs_sram_end.sv
`timescale 1ns/10ps
`default_nettype none
module dbs_sram_end #(
   parameter int DATA_W = dbs_pkg::DATA_W_DEF,
   parameter int ADDR_W = dbs_pkg::ADDR_W_DEF,
   parameter int LANES  = dbs_pkg::LANES_DEF
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // Memory bus
   dbs_bus_if.dev    bus,
   // Status
   output logic      pllOffMode
);

   localparam int PD = dbs_pkg::PIPE_DEPTH;

   // ==========================================================
   // Helpers

   // Burst counter: the second beat uses the loaded address plus one.
   function automatic logic [ADDR_W-1:0] burstAddr(input logic [ADDR_W-1:0] a);
      burstAddr = a + 1'b1;
   endfunction : burstAddr

   // Lane merge: a low mask bit lets its nine bits through.
   function automatic logic [DATA_W-1:0] mergeLanes(
      input logic [DATA_W-1:0] oldWord,
      input logic [DATA_W-1:0] newWord,
      input logic [LANES-1:0]  maskN
   );
      logic [DATA_W-1:0] w;
      w = oldWord;
      for (int l = 0; l < LANES; l++) begin
         if (!maskN[l]) begin
            w[l*dbs_pkg::LANE_W +: dbs_pkg::LANE_W] =
               newWord[l*dbs_pkg::LANE_W +: dbs_pkg::LANE_W];
         end
      end
      mergeLanes = w;
   endfunction : mergeLanes

   // ==========================================================
   // Storage
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // ==========================================================
   // State
   logic              halfEv;
   logic              newRead;
   logic              newWrite;
   logic [PD-1:0]     rdPipe_q;
   logic [PD-1:0]     rdPipe_d;
   logic [PD-1:0]     wrPipe_q;
   logic [PD-1:0]     wrPipe_d;
   logic [ADDR_W-1:0] addrPipe_q [0:PD-1];
   logic [ADDR_W-1:0] addrPipe_d [0:PD-1];
   logic [DATA_W-1:0] dqOut_q;
   logic [DATA_W-1:0] dqOut_d;
   logic              dqOe_q;
   logic              dqOe_d;
   logic              valid_q;
   logic              valid_d;
   logic              termOff_q;
   logic              termOff_d;
   logic              echo_q;
   logic              echo_d;
   logic              pllOff_q;
   logic              pllOff_d;
   logic              wrEn;
   logic [ADDR_W-1:0] wrAddr;
   logic [DATA_W-1:0] wrData;

   // ==========================================================
   // Command decode
   // Every step of the pipe is tied to a clock phase, so with the clocks
   // stopped nothing moves and every output except termRangeHigh keeps its last value.
   assign halfEv   = bus.kRise | bus.kbRise;
   assign newRead  = bus.kRise & ~bus.cycleLoadN & bus.rdWrN;
   assign newWrite = bus.kRise & ~bus.cycleLoadN & ~bus.rdWrN;
   // With the load strobe high neither token enters, so no operation
   // starts and the select is ignored.

   // ==========================================================
   // Pipeline of half-period stages
   always_comb begin
      rdPipe_d = rdPipe_q;
      wrPipe_d = wrPipe_q;
      for (int i = 0; i < PD; i++) begin
         addrPipe_d[i] = addrPipe_q[i];
      end
      if (halfEv) begin
         rdPipe_d      = {rdPipe_q[PD-2:0], newRead};
         wrPipe_d      = {wrPipe_q[PD-2:0], newWrite};
         addrPipe_d[0] = bus.addr;
         for (int i = 1; i < PD; i++) begin
            addrPipe_d[i] = addrPipe_q[i-1];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdPipe_q <= '0;
         wrPipe_q <= '0;
         for (int i = 0; i < PD; i++) begin
            addrPipe_q[i] <= '0;
         end
      end else begin
         rdPipe_q <= rdPipe_d;
         wrPipe_q <= wrPipe_d;
         for (int i = 0; i < PD; i++) begin
            addrPipe_q[i] <= addrPipe_d[i];
         end
      end
   end

   // ==========================================================
   // Write capture
   // The first beat is taken on the next true rise and the second on the
   // following complement rise; the burst then ends.
   always_comb begin
      wrEn   = halfEv & (wrPipe_d[dbs_pkg::WR_WORD0_STAGE] |
                         wrPipe_d[dbs_pkg::WR_WORD1_STAGE]);
      wrAddr = addrPipe_d[dbs_pkg::WR_WORD0_STAGE];
      if (!wrPipe_d[dbs_pkg::WR_WORD0_STAGE]) begin
         wrAddr = burstAddr(addrPipe_d[dbs_pkg::WR_WORD1_STAGE]);
      end
      wrData = mergeLanes(mem[wrAddr], bus.dq, bus.byteLaneWriteMaskN);
   end

   // The array is left unreset: contents are undefined until written.
   always_ff @(posedge ref_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // ==========================================================
   // Read launch, valid flag, termination and echo clocks
   // All of these are registered on the same phase enable, which keeps
   // the valid flag and the data edge-aligned with the echo clocks.
   always_comb begin
      dqOut_d   = dqOut_q;
      dqOe_d    = dqOe_q;
      valid_d   = valid_q;
      termOff_d = termOff_q;
      echo_d    = echo_q;
      pllOff_d  = pllOff_q;
      if (halfEv) begin
         echo_d   = bus.kRise;
         pllOff_d = ~bus.pllBypassN;
         if (rdPipe_d[dbs_pkg::RD_WORD0_STAGE]) begin
            dqOut_d = mem[addrPipe_d[dbs_pkg::RD_WORD0_STAGE]];
         end else if (rdPipe_d[dbs_pkg::RD_WORD1_STAGE]) begin
            dqOut_d = mem[burstAddr(addrPipe_d[dbs_pkg::RD_WORD1_STAGE])];
         end
         dqOe_d    = rdPipe_d[dbs_pkg::RD_WORD0_STAGE] |
                     rdPipe_d[dbs_pkg::RD_WORD1_STAGE];
         valid_d   = rdPipe_d[dbs_pkg::VALID_FIRST] |
                     rdPipe_d[dbs_pkg::VALID_LAST];
         termOff_d = |rdPipe_d[dbs_pkg::TERM_OFF_LAST:dbs_pkg::TERM_OFF_FIRST];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dqOut_q   <= '0;
         dqOe_q    <= 1'b0;
         valid_q   <= 1'b0;
         termOff_q <= 1'b0;
         echo_q    <= 1'b0;
         pllOff_q  <= 1'b0;
      end else begin
         dqOut_q   <= dqOut_d;
         dqOe_q    <= dqOe_d;
         valid_q   <= valid_d;
         termOff_q <= termOff_d;
         echo_q    <= echo_d;
         pllOff_q  <= pllOff_d;
      end
   end

   // ==========================================================
   // Outputs
   assign bus.devDqOut       = dqOut_q;
   assign bus.devDqOe        = dqOe_q;
   assign bus.readValidFlag  = valid_q;
   assign bus.echoClockPair  = echo_q;
   assign bus.echoClockPairN = ~echo_q;
   // Data termination is dropped for a window one half period wider on each
   // side than the driven data, so it never loads our own drivers.
   assign bus.dqTermEn       = ~termOff_q;
   assign bus.maskTermEn     = 1'b1;
   assign bus.clkTermEn      = 1'b1;
   // The range output follows the select pin as driven, with no pull to high for a floating pin.
   assign bus.termRangeHigh  = bus.terminationRangeSelect;
   assign pllOffMode         = pllOff_q;

endmodule : dbs_sram_end
`default_nettype wire

// >>> verilog/dbs_ctrl_end.sv
`timescale 1ns/10ps
`default_nettype none
module dbs_ctrl_end #(
   parameter int DATA_W   = dbs_pkg::DATA_W_DEF,
   parameter int ADDR_W   = dbs_pkg::ADDR_W_DEF,
   parameter int LANES    = dbs_pkg::LANES_DEF,
   parameter int HALF_DIV = dbs_pkg::HALF_DIV_DEF
) (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   // Memory bus
   dbs_bus_if.ctl                 bus,
   // Mode control
   input  wire logic              pllBypassReq,
   input  wire logic              termRangeReq,
   input  wire logic              clkStop,
   output logic                   setupDone,
   // Request
   input  wire logic              reqValid,
   input  wire logic              reqWrite,
   input  wire logic [ADDR_W-1:0] reqAddr,
   input  wire logic [DATA_W-1:0] reqData0,
   input  wire logic [DATA_W-1:0] reqData1,
   input  wire logic [LANES-1:0]  reqMask0N,
   input  wire logic [LANES-1:0]  reqMask1N,
   output logic                   reqReady,
   // Read response
   output logic                   rspValid,
   output logic [DATA_W-1:0]      rspData0,
   output logic [DATA_W-1:0]      rspData1
);

   localparam int DIV_W = $clog2(HALF_DIV + 1);
   localparam logic [dbs_pkg::SETUP_CNT_W-1:0] SETUP_MAX =
      dbs_pkg::SETUP_CNT_W'(dbs_pkg::SETUP_CYCLES);

   // ==========================================================
   // State
   logic [DIV_W-1:0]  div_q, div_d;
   logic              kLvl_q, kLvl_d;
   logic              tick, running;
   logic              pllN_q, pllN_d;
   logic              range_q, range_d;
   logic [dbs_pkg::SETUP_CNT_W-1:0] setup_q, setup_d;
   dbs_pkg::dbs_state_e st_q, st_d;
   logic [3:0]        hc_q, hc_d;
   logic              load_q, load_d;
   logic              rw_q, rw_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] w0_q, w0_d, w1_q, w1_d;
   logic [LANES-1:0]  m0_q, m0_d, m1_q, m1_d;
   logic [DATA_W-1:0] dqo_q, dqo_d;
   logic              oe_q, oe_d;
   logic [LANES-1:0]  bw_q, bw_d;
   logic              got_q, got_d;
   logic              rsp_q, rsp_d;
   logic [DATA_W-1:0] r0_q, r0_d, r1_q, r1_d;

   // ==========================================================
   // Clock generation and setup period
   // With the PLL in use the clocks may not stop, since stopped clocks fall
   // below its lowest frequency; the stop request is then ignored.
   assign running = ~clkStop | pllN_q;
   assign tick    = running && (div_q == DIV_W'(HALF_DIV - 1));
   // Stopping only happens between phases, so true and complement are
   // parked at opposite levels.
   assign bus.kRise  = tick & ~kLvl_q;
   assign bus.kbRise = tick & kLvl_q;
   assign bus.kLevel = kLvl_q;
   assign setupDone  = (setup_q == SETUP_MAX);
   assign reqReady   = (st_q == dbs_pkg::ST_IDLE) & setupDone & bus.kbRise;

   always_comb begin
      div_d   = running ? (tick ? '0 : div_q + 1'b1) : div_q;
      kLvl_d  = tick ? ~kLvl_q : kLvl_q;
      pllN_d  = pllBypassReq;
      range_d = termRangeReq;
      setup_d = setup_q;
      if (pllN_q != pllBypassReq) begin
         setup_d = '0;
      end else if (running && !setupDone) begin
         setup_d = setup_q + 1'b1;
      end
   end

   // ==========================================================
   // Transfer sequencing, stepped once per clock phase
   always_comb begin
      st_d = st_q;
      hc_d = hc_q;
      load_d = load_q;
      rw_d = rw_q;
      addr_d = addr_q;
      w0_d = w0_q;
      w1_d = w1_q;
      m0_d = m0_q;
      m1_d = m1_q;
      dqo_d = dqo_q;
      oe_d = oe_q;
      bw_d = bw_q;
      got_d = got_q;
      rsp_d = 1'b0;
      r0_d = r0_q;
      r1_d = r1_q;
      if (tick) begin
         hc_d = hc_q + 1'b1;
         case (st_q)
            dbs_pkg::ST_IDLE: begin
               if (reqReady && reqValid) begin
                  load_d = 1'b0;
                  rw_d   = ~reqWrite;
                  addr_d = reqAddr;
                  w0_d   = reqData0;
                  w1_d   = reqData1;
                  m0_d   = reqMask0N;
                  m1_d   = reqMask1N;
                  hc_d   = '0;
                  got_d  = 1'b0;
                  st_d   = reqWrite ? dbs_pkg::ST_WRITE : dbs_pkg::ST_READ;
               end
            end
            dbs_pkg::ST_WRITE: begin
               load_d = 1'b1;
               if (hc_q == 4'h1) begin
                  dqo_d = w0_q;
                  bw_d  = m0_q;
                  oe_d  = 1'b1;
               end else if (hc_q == 4'h2) begin
                  dqo_d = w1_q;
                  bw_d  = m1_q;
               end else if (hc_q == 4'h3) begin
                  oe_d = 1'b0;
                  bw_d = '1;
                  st_d = dbs_pkg::ST_IDLE;
               end
            end
            dbs_pkg::ST_READ: begin
               load_d = 1'b1;
               if (bus.devDqOe) begin
                  got_d = 1'b1;
                  if (!got_q) begin
                     r0_d = bus.dq;
                  end else begin
                     r1_d  = bus.dq;
                     rsp_d = 1'b1;
                     st_d  = dbs_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               st_d   = dbs_pkg::ST_IDLE;
               load_d = 1'b1;
               oe_d   = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_q <= '0;
         kLvl_q <= 1'b0;
         pllN_q <= 1'b0;
         range_q <= 1'b1;
         setup_q <= '0;
         st_q <= dbs_pkg::ST_IDLE;
         hc_q <= '0;
         load_q <= 1'b1;
         rw_q <= 1'b0;
         addr_q <= '0;
         w0_q <= '0;
         w1_q <= '0;
         m0_q <= '1;
         m1_q <= '1;
         dqo_q <= '0;
         oe_q <= 1'b0;
         bw_q <= '1;
         got_q <= 1'b0;
         rsp_q <= 1'b0;
         r0_q <= '0;
         r1_q <= '0;
      end else begin
         div_q <= div_d;
         kLvl_q <= kLvl_d;
         pllN_q <= pllN_d;
         range_q <= range_d;
         setup_q <= setup_d;
         st_q <= st_d;
         hc_q <= hc_d;
         load_q <= load_d;
         rw_q <= rw_d;
         addr_q <= addr_d;
         w0_q <= w0_d;
         w1_q <= w1_d;
         m0_q <= m0_d;
         m1_q <= m1_d;
         dqo_q <= dqo_d;
         oe_q <= oe_d;
         bw_q <= bw_d;
         got_q <= got_d;
         rsp_q <= rsp_d;
         r0_q <= r0_d;
         r1_q <= r1_d;
      end
   end

   // ==========================================================
   // Outputs
   assign bus.cycleLoadN             = load_q;
   assign bus.rdWrN                  = rw_q;
   assign bus.addr                   = addr_q;
   assign bus.byteLaneWriteMaskN     = bw_q;
   assign bus.pllBypassN             = pllN_q;
   assign bus.terminationRangeSelect = range_q;
   assign bus.ctlDqOut               = dqo_q;
   assign bus.ctlDqOe                = oe_q;
   assign rspValid                   = rsp_q;
   assign rspData0                   = r0_q;
   assign rspData1                   = r1_q;

endmodule : dbs_ctrl_end
`default_nettype wire

// >>> dv/dbs_bus_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module dbs_bus_monitor #(
   parameter int DATA_W = 36
) (
   // Clock and reset
   input wire logic              ref_clk,
   input wire logic              rst_b,
   // Controller drive
   input wire logic              kRise,
   input wire logic              kbRise,
   input wire logic              cycleLoadN,
   input wire logic              rdWrN,
   input wire logic              terminationRangeSelect,
   // Device drive
   input wire logic [DATA_W-1:0] devDqOut,
   input wire logic              devDqOe,
   input wire logic              readValidFlag,
   input wire logic              echoClockPair,
   input wire logic              echoClockPairN,
   input wire logic              dqTermEn,
   input wire logic              maskTermEn,
   input wire logic              clkTermEn,
   input wire logic              termRangeHigh
);
   // ==========================================================
   // Burst phases
   // The windows assume two ref_clk cycles per half clock period.
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   sequence rdCmd;
      kRise && !cycleLoadN && rdWrN;
   endsequence
   sequence wrCmd;
      kRise && !cycleLoadN && !rdWrN;
   endsequence
   // The flag is registered on the fourth phase event, so it is first seen
   // high nine cycles after the command.
   sequence validWin;
      !readValidFlag [*8] ##1 !readValidFlag ##1 readValidFlag [*4] ##1 !readValidFlag;
   endsequence
   // A read in flight raises the flag one cycle after its fourth event, so a
   // quiet cycle is only trusted once the flag has stayed low one cycle more.
   sequence nopQuiet;
      kRise && cycleLoadN && dqTermEn && !readValidFlag && !devDqOe ##1 !readValidFlag;
   endsequence
   sequence driveWin;
      ##10 !devDqOe ##1 devDqOe [*4] ##1 !devDqOe;
   endsequence
   sequence termWin;
      ##8 dqTermEn ##1 !dqTermEn [*8] ##1 dqTermEn;
   endsequence

   // ==========================================================
   // Checks
   a_valid_window: assert property (rdCmd |-> validWin)
      else $error("read valid window misplaced");
   a_drive_window: assert property (rdCmd |-> driveWin)
      else $error("read data drive window misplaced");
   a_term_window: assert property (rdCmd |-> termWin)
      else $error("bus termination window misplaced");
   a_write_quiet: assert property (wrCmd |-> (!devDqOe && dqTermEn) [*8])
      else $error("device drove bus during write");
   a_echo_align: assert property ($changed(readValidFlag) |-> $changed(echoClockPair))
      else $error("valid flag not aligned with echo clock");
   a_echo_phase: assert property ((kRise || kbRise) |=> echoClockPair == $past(kRise))
      else $error("echo clock not following clock phase");
   a_nop_idle: assert property (nopQuiet |-> !devDqOe [*4])
      else $error("idle cycle drove bus");
   a_echo_compl: assert property (echoClockPairN == !echoClockPair)
      else $error("echo clock pair not complementary");
   a_stop_hold: assert property (!kRise && !kbRise |=> $stable({readValidFlag, devDqOe,
                                 devDqOut, echoClockPair, dqTermEn}))
      else $error("outputs changed without clock edge");
   a_lane_term: assert property (maskTermEn && clkTermEn)
      else $error("mask or clock termination off");
   a_range_follow: assert property (termRangeHigh == terminationRangeSelect)
      else $error("termination range mismatch");
endmodule : dbs_bus_monitor
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   typedef struct packed {
      logic        wr;
      logic [19:0] addr;
      logic [35:0] d0;
      logic [35:0] d1;
      logic [3:0]  m0;
      logic [3:0]  m1;
   } dbs_row_s;

   localparam dbs_row_s ROWS [10] = '{
      '{1'b1, 20'h00010, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0},
      '{1'b1, 20'h00020, 36'h0a5a5a5a5, 36'h05a5a5a5a, 4'h0, 4'h0},
      '{1'b0, 20'h00010, 36'h0, 36'h0, 4'hf, 4'hf},
      '{1'b1, 20'h00010, 36'h111111111, 36'h222222222, 4'he, 4'h7},
      '{1'b0, 20'h00010, 36'h0, 36'h0, 4'hf, 4'hf},
      '{1'b1, 20'h00020, 36'h333333333, 36'h444444444, 4'hd, 4'hb},
      '{1'b1, 20'h00020, 36'hfffffffff, 36'hfffffffff, 4'hf, 4'hf},
      '{1'b0, 20'h00020, 36'h0, 36'h0, 4'hf, 4'hf},
      '{1'b1, 20'hfffff, 36'h0c0ffee01, 36'h0beef0002, 4'h0, 4'h0},
      '{1'b0, 20'hfffff, 36'h0, 36'h0, 4'hf, 4'hf}
   };

   logic        ref_clk;
   logic        rst_b;
   logic        pllBypassReq;
   logic        termRangeReq;
   logic        clkStop;
   logic        setupDone;
   logic        pllOffMode;
   logic        reqValid;
   logic        reqWrite;
   logic [19:0] reqAddr;
   logic [35:0] reqData0;
   logic [35:0] reqData1;
   logic [3:0]  reqMask0N;
   logic [3:0]  reqMask1N;
   logic        reqReady;
   logic        rspValid;
   logic [35:0] rspData0;
   logic [35:0] rspData1;
   logic [35:0] mem [logic [19:0]];
   int          fail_count = 0;
   int          comparisons = 0;

   dbs_bus_if u_dbs_bus_if ();

   dbs_sram_end u_dbs_sram_end (.ref_clk(ref_clk), .rst_b(rst_b), .bus(u_dbs_bus_if),
                                .pllOffMode(pllOffMode));
   dbs_ctrl_end u_dbs_ctrl_end (.ref_clk(ref_clk), .rst_b(rst_b), .bus(u_dbs_bus_if),
      .pllBypassReq(pllBypassReq), .termRangeReq(termRangeReq), .clkStop(clkStop),
      .setupDone(setupDone), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
      .reqData0(reqData0), .reqData1(reqData1), .reqMask0N(reqMask0N),
      .reqMask1N(reqMask1N), .reqReady(reqReady), .rspValid(rspValid),
      .rspData0(rspData0), .rspData1(rspData1));

   dbs_bus_monitor u_dbs_bus_monitor (.ref_clk(ref_clk), .rst_b(rst_b),
      .kRise(u_dbs_bus_if.kRise), .kbRise(u_dbs_bus_if.kbRise),
      .cycleLoadN(u_dbs_bus_if.cycleLoadN), .rdWrN(u_dbs_bus_if.rdWrN),
      .terminationRangeSelect(u_dbs_bus_if.terminationRangeSelect),
      .devDqOut(u_dbs_bus_if.devDqOut), .devDqOe(u_dbs_bus_if.devDqOe),
      .readValidFlag(u_dbs_bus_if.readValidFlag), .echoClockPair(u_dbs_bus_if.echoClockPair),
      .echoClockPairN(u_dbs_bus_if.echoClockPairN),
      .dqTermEn(u_dbs_bus_if.dqTermEn), .maskTermEn(u_dbs_bus_if.maskTermEn),
      .clkTermEn(u_dbs_bus_if.clkTermEn), .termRangeHigh(u_dbs_bus_if.termRangeHigh));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ==========================================================
   // Helpers
   task automatic end_sim();
      if (fail_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                         input logic [3:0] mN);
      for (int l = 0; l < 4; l++) begin
         if (!mN[l]) begin
            o[l*9 +: 9] = n[l*9 +: 9];
         end
      end
      return o;
   endfunction : merge

   // Called just after a falling edge; the request is held until a ready edge.
   task automatic op(input dbs_row_s r);
      int i;
      {reqWrite, reqAddr, reqData0, reqData1, reqMask0N, reqMask1N} = r;
      reqValid = 1'b1;
      for (i = 0; i < 3000 && reqReady !== 1'b1; i++) begin
         @(negedge ref_clk);
      end
      if (i == 3000) begin
         fail_count++;
         end_sim();
      end
      @(negedge ref_clk);
      reqValid = 1'b0;
      if (r.wr) begin
         mem[r.addr] = merge(mem[r.addr], r.d0, r.m0);
         mem[r.addr + 20'h1] = merge(mem[r.addr + 20'h1], r.d1, r.m1);
      end else begin
         for (i = 0; i < 100 && rspValid !== 1'b1; i++) begin
            @(negedge ref_clk);
         end
         // A lost answer would otherwise compare stale data from an earlier read.
         if (i == 100) begin
            fail_count++;
            end_sim();
         end
         check("rspData0", rspData0, mem[r.addr]);
         check("rspData1", rspData1, mem[r.addr + 20'h1]);
      end
   endtask : op

   // ==========================================================
   // Main sequence
   initial begin
      int n;
      rst_b = 1'b0;
      {pllBypassReq, clkStop, reqValid, reqWrite} = '0;
      termRangeReq = 1'b1;
      {reqAddr, reqData0, reqData1} = '0;
      {reqMask0N, reqMask1N} = '1;
      repeat (8) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (1990) @(negedge ref_clk);
      check("setupDone", 36'(setupDone), 36'h0);
      check("pllOffMode", 36'(pllOffMode), 36'h1);
      for (int i = 0; i < 10; i++) begin
         @(negedge ref_clk);
         op(ROWS[i]);
      end
      // Range select both ways.
      for (int v = 0; v < 2; v++) begin
         termRangeReq = v[0];
         repeat (4) @(negedge ref_clk);
         check("termRangeHigh", 36'(u_dbs_bus_if.termRangeHigh), 36'(v[0]));
      end
      // Stopped clocks must freeze the bus, then a read must still work.
      clkStop = 1'b1;
      repeat (8) @(negedge ref_clk);
      n = 0;
      repeat (20) begin
         @(negedge ref_clk);
         n += int'(u_dbs_bus_if.kRise | u_dbs_bus_if.kbRise);
      end
      check("clockEvents", 36'(n), 36'h0);
      check("devDqOe", 36'(u_dbs_bus_if.devDqOe), 36'h0);
      clkStop = 1'b0;
      op(ROWS[9]);
      // A bypass change restarts the setup period.
      pllBypassReq = 1'b1;
      repeat (4) @(negedge ref_clk);
      check("setupDone", 36'(setupDone), 36'h0);
      check("pllBypassN", 36'(u_dbs_bus_if.pllBypassN), 36'h1);
      check("pllOffMode", 36'(pllOffMode), 36'h0);
      // With the PLL in use a stop request must not halt the clocks.
      clkStop = 1'b1;
      n = 0;
      repeat (20) begin
         @(negedge ref_clk);
         n += int'(u_dbs_bus_if.kRise | u_dbs_bus_if.kbRise);
      end
      check("clockEvents", 36'(n), 36'd10);
      clkStop = 1'b0;
      op(ROWS[4]);
      // Reset in mid-run leaves the bus released.
      rst_b = 1'b0;
      #1;
      check("devDqOe", 36'(u_dbs_bus_if.devDqOe), 36'h0);
      check("cycleLoadN", 36'(u_dbs_bus_if.cycleLoadN), 36'h1);
      repeat (8) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge ref_clk);
      check("readValidFlag", 36'(u_dbs_bus_if.readValidFlag), 36'h0);
      end_sim();
   end
endmodule : tb
`default_nettype wire
